// ==== selk_datapath.sv ====
// Offset and sensitivity arithmetic with saturation
`timescale 1ns/1ps
module selk_datapath (
    input  wire logic  clk,
    input  wire logic  sys_rst,
    input  wire logic  ce,
    selk_dp_if.path    dp
);
    typedef struct packed {
        logic [15:0] result;
        logic        overflow;
    } selk_dp_s;

    selk_dp_s          st_reg;
    selk_dp_s          st_next;
    logic signed [10:0] off_ext;
    logic signed [11:0] diff;
    logic signed [19:0] prod;
    logic signed [13:0] scaled;

    // Scale offset, subtract, multiply, saturate to ten bits
    always_comb begin
        st_next = st_reg;
        off_ext = dp.offset_alignment_select ?
                  (11'(dp.offset) <<< selk_pkg::OFFSET_ALIGNMENT_SELECT_SHIFT) : 11'(dp.offset);
        diff    = 12'(dp.adc_value) - 12'(off_ext);
        prod    = 20'(diff) * 20'(dp.sens);
        scaled  = 14'(prod >>> selk_pkg::SENS_FRAC);
        if (scaled > 14'(selk_pkg::OUT_MAX)) begin
            st_next.result   = 16'(selk_pkg::OUT_MAX);
            st_next.overflow = 1'b1;
        end else if (scaled < 14'(selk_pkg::OUT_MIN)) begin
            st_next.result   = 16'(selk_pkg::OUT_MIN);
            st_next.overflow = 1'b1;
        end else begin
            st_next.result   = 16'(scaled);
            st_next.overflow = 1'b0;
        end
    end

    // State register
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            st_reg <= '0;
        end else if (ce) begin
            st_reg <= st_next;
        end
    end

    assign dp.result   = st_reg.result;
    assign dp.overflow = st_reg.overflow;

    a_result_sign: assert property (@(posedge clk) disable iff (sys_rst)
        dp.result[15:10] == {6{dp.result[9]}})
        else $error("Result upper bits not sign extension");
    a_zero_sens: assert property (@(posedge clk) disable iff (sys_rst)
        (ce && dp.sens == 8'sh00) |=> (dp.result == selk_pkg::WORD_ZERO))
        else $error("Zero sensitivity gave nonzero result");
    a_unity_path: assert property (@(posedge clk) disable iff (sys_rst)
        (ce && dp.sens == 8'sh40 && !dp.offset_alignment_select
         && dp.adc_value == 10'sh000) |=> (dp.result == 16'(-$past(11'(dp.offset)))))
        else $error("Quarter scale offset not applied");
endmodule

// ==== selk_dp_if.sv ====
// Carrier between the register bank and the processing path
`timescale 1ns/1ps
interface selk_dp_if;
    logic signed [7:0]  sens;
    logic signed [7:0]  offset;
    logic               offset_alignment_select;
    logic signed [9:0]  adc_value;
    logic [15:0]        result;
    logic               overflow;
    modport bank (output sens, output offset, output offset_alignment_select,
                  output adc_value, input result, input overflow);
    modport path (input sens, input offset, input offset_alignment_select,
                  input adc_value, output result, output overflow);
endinterface

// ==== selk_pkg.sv ====
// Shared constants for the sensor lock and datapath block
package selk_pkg;
    // Programmer command addresses
    localparam logic [2:0] ADDR_CUST_I   = 3'h0;
    localparam logic [2:0] ADDR_CUST_II  = 3'h1;
    localparam logic [2:0] ADDR_PROD_A   = 3'h2;
    localparam logic [2:0] ADDR_PROD_B   = 3'h3;
    localparam logic [2:0] ADDR_DIG_OUT  = 3'h4;
    // Customer register I layout
    localparam int SENS_LSB   = 8;
    localparam int OFFSET_LSB = 0;
    // Customer register II layout
    localparam int MRANGE_LSB = 0;
    localparam int TC_LSB     = 3;
    localparam int TCSQ_LSB   = 8;
    localparam int OFFSET_ALIGNMENT_SELECT_BIT   = 13;
    localparam int LOCK_BIT   = 14;
    localparam logic [15:0] CUST_II_MASK = 16'h7FFF;
    // Erased values
    localparam logic [15:0] CUST_ERASED  = 16'h0000;
    localparam logic [15:0] WORD_ZERO    = 16'h0000;
    // Datapath widths and limits
    localparam int SENS_FRAC = 6;
    localparam int OFFSET_ALIGNMENT_SELECT_SHIFT = 2;
    localparam logic signed [9:0] OUT_MAX = 10'sh1FF;
    localparam logic signed [9:0] OUT_MIN = -10'sh200;
endpackage

// ==== selk_prog.sv ====
// Programmer model issuing read and write commands
`timescale 1ns/1ps
module selk_prog (
    input  wire logic        clk,
    input  wire logic        rsp_valid,
    input  wire logic        rsp_refused,
    input  wire logic [15:0] rsp_rdata,
    output logic             cmd_valid,
    output logic             cmd_write,
    output logic [2:0]       cmd_addr,
    output logic [15:0]      cmd_wdata
);
    // Idle command lines at time zero
    initial begin
        cmd_valid = 1'b0;
        cmd_write = 1'b0;
        cmd_addr  = 3'h0;
        cmd_wdata = 16'h0000;
    end
    // One command; idle lines show inverted values, answer taken next cycle
    task automatic xfer(input logic wr, input logic [2:0] a, input logic [15:0] d,
                        output logic [15:0] q, output logic rf, output logic ok);
        @(negedge clk);
        cmd_valid = 1'b1;
        cmd_write = wr;
        cmd_addr  = a;
        cmd_wdata = d;
        @(negedge clk);
        cmd_valid = 1'b0;
        cmd_write = ~wr;
        cmd_addr  = ~a;
        cmd_wdata = ~d;
        ok = rsp_valid;
        q  = rsp_rdata;
        rf = rsp_refused;
    endtask
endmodule

// ==== selk_top.sv ====
// Customer register bank with deferred permanent lock
// Behaviour
// - Once lock is active, every customer register write is refused.
// - Reads keep working and return every register after locking.
// - Setting the lock flag blocks writes only after the next power cycle.
// - The lock flag, once set, is never cleared by command or reset.
// - Two read-only sixteen bit production registers are readable.
// - Output equals sensitivity times (input minus offset).
// - Offset and sensitivity are eight bit two's complement values.
// - Alignment select one gives full-range offset, zero gives quarter range.
// - Sensitivity code spans multipliers from minus two to just under plus two.
// - Result register is sixteen bits, ten low bits hold signed value.
`timescale 1ns/1ps
module selk_top (
    input  wire logic              clk,
    input  wire logic              sys_rst,
    input  wire logic              ce,
    input  wire logic              prod_load,
    input  wire logic [15:0]       prod_data_a,
    input  wire logic [15:0]       prod_data_b,
    input  wire logic signed [9:0] adc_value,
    input  wire logic              cmd_valid,
    input  wire logic              cmd_write,
    input  wire logic [2:0]        cmd_addr,
    input  wire logic [15:0]       cmd_wdata,
    output logic                   rsp_valid,
    output logic                   rsp_refused,
    output logic [15:0]            rsp_rdata,
    output logic                   lock_active,
    output logic                   dsp_overflow
);
    typedef struct packed {
        logic [15:0] cust_i;
        logic [15:0] cust_ii;
        logic [15:0] prod_a;
        logic [15:0] prod_b;
        logic        lock_active;
        logic        rsp_valid;
        logic        rsp_refused;
        logic [15:0] rsp_rdata;
    } selk_bank_s;

    selk_bank_s st_reg;
    selk_bank_s st_next;
    logic       wr_req;
    logic       rd_req;
    logic       flag_stored;

    selk_dp_if dp ();

    selk_datapath u_path (
        .clk     (clk),
        .sys_rst (sys_rst),
        .ce      (ce),
        .dp      (dp.path)
    );

    // Feed stored parameters to the processing path
    assign dp.sens   = st_reg.cust_i[selk_pkg::SENS_LSB +: 8];
    assign dp.offset = st_reg.cust_i[selk_pkg::OFFSET_LSB +: 8];
    assign dp.offset_alignment_select = st_reg.cust_ii[selk_pkg::OFFSET_ALIGNMENT_SELECT_BIT];
    assign dp.adc_value = adc_value;

    assign flag_stored = st_reg.cust_ii[selk_pkg::LOCK_BIT];
    assign wr_req      = cmd_valid && cmd_write;
    assign rd_req      = cmd_valid && !cmd_write;

    // Command decode, write gating and read mux
    always_comb begin
        st_next             = st_reg;
        st_next.rsp_valid   = cmd_valid;
        st_next.rsp_refused = 1'b0;
        st_next.rsp_rdata   = selk_pkg::WORD_ZERO;
        if (rd_req) begin
            unique case (cmd_addr)
                selk_pkg::ADDR_CUST_I:  st_next.rsp_rdata = st_reg.cust_i;
                selk_pkg::ADDR_CUST_II: st_next.rsp_rdata = st_reg.cust_ii;
                selk_pkg::ADDR_PROD_A:  st_next.rsp_rdata = st_reg.prod_a;
                selk_pkg::ADDR_PROD_B:  st_next.rsp_rdata = st_reg.prod_b;
                selk_pkg::ADDR_DIG_OUT: st_next.rsp_rdata = dp.result;
                default:                st_next.rsp_refused = 1'b1;
            endcase
        end else if (wr_req) begin
            if (st_reg.lock_active) begin
                st_next.rsp_refused = 1'b1;
            end else begin
                unique case (cmd_addr)
                    selk_pkg::ADDR_CUST_I: st_next.cust_i = cmd_wdata;
                    selk_pkg::ADDR_CUST_II: begin
                        // Flag only ORs in, never clears; latch untouched here
                        st_next.cust_ii = cmd_wdata & selk_pkg::CUST_II_MASK;
                        st_next.cust_ii[selk_pkg::LOCK_BIT] =
                            flag_stored | cmd_wdata[selk_pkg::LOCK_BIT];
                    end
                    default: st_next.rsp_refused = 1'b1;
                endcase
            end
        end
        // Factory initialisation of production words and erased array
        if (prod_load) begin
            st_next.prod_a  = prod_data_a;
            st_next.prod_b  = prod_data_b;
            st_next.cust_i  = selk_pkg::CUST_ERASED;
            st_next.cust_ii = selk_pkg::CUST_ERASED;
        end
    end

    // State register; power-on keeps array and copies flag to latch
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            st_reg.lock_active <= flag_stored && !prod_load;
            st_reg.rsp_valid   <= 1'b0;
            st_reg.rsp_refused <= 1'b0;
            st_reg.rsp_rdata   <= selk_pkg::WORD_ZERO;
            // Factory initialisation may also happen under power-on
            if (prod_load) begin
                st_reg.prod_a  <= prod_data_a;
                st_reg.prod_b  <= prod_data_b;
                st_reg.cust_i  <= selk_pkg::CUST_ERASED;
                st_reg.cust_ii <= selk_pkg::CUST_ERASED;
            end
        end else if (ce) begin
            st_reg <= st_next;
        end
    end

    assign rsp_valid    = st_reg.rsp_valid;
    assign rsp_refused  = st_reg.rsp_refused;
    assign rsp_rdata    = st_reg.rsp_rdata;
    assign lock_active  = st_reg.lock_active;
    assign dsp_overflow = dp.overflow;

    a_locked_refuse: assert property (@(posedge clk) disable iff (sys_rst)
        (ce && wr_req && st_reg.lock_active && !prod_load) |=>
        (rsp_refused && st_reg.cust_i == $past(st_reg.cust_i)
         && st_reg.cust_ii == $past(st_reg.cust_ii)))
        else $error("Write accepted while locked");
    a_locked_read: assert property (@(posedge clk) disable iff (sys_rst)
        (ce && rd_req && cmd_addr == selk_pkg::ADDR_CUST_I && lock_active
         && !prod_load) |=> (rsp_valid && !rsp_refused
         && rsp_rdata == $past(st_reg.cust_i)))
        else $error("Read failed while locked");
    a_lock_deferred: assert property (@(posedge clk)
        (!sys_rst && !$past(sys_rst)) |-> (lock_active == $past(lock_active)))
        else $error("Lock latch changed without power cycle");
    a_flag_sticky: assert property (@(posedge clk) disable iff (sys_rst)
        (flag_stored && !prod_load) |=> flag_stored)
        else $error("Stored lock flag cleared");
    a_prod_readonly: assert property (@(posedge clk) disable iff (sys_rst)
        (ce && wr_req && cmd_addr == selk_pkg::ADDR_PROD_A && !prod_load) |=>
        (rsp_refused && st_reg.prod_a == $past(st_reg.prod_a)))
        else $error("Production register altered");
    a_poweron_copy: assert property (@(posedge clk)
        sys_rst |=> (lock_active == $past(flag_stored && !prod_load)))
        else $error("Power-on did not copy lock flag");
    a_unlocked_write: assert property (@(posedge clk) disable iff (sys_rst)
        (ce && wr_req && !lock_active && cmd_addr == selk_pkg::ADDR_CUST_I
         && !prod_load) |=> (st_reg.cust_i == $past(cmd_wdata) && !rsp_refused))
        else $error("Unlocked write not stored");
    a_sens_route: assert property (@(posedge clk) disable iff (sys_rst)
        dp.sens == st_reg.cust_i[15:8])
        else $error("Sensitivity field misrouted");
endmodule

// ==== test_sensor_eeprom_lock_and_datapath.sv ====
// Self-checking bench for lock, production words and datapath
`timescale 1ns/1ps
module test_sensor_eeprom_lock_and_datapath;
    logic              clk, sys_rst, ce, prod_load, ok, rf;
    logic              cmd_valid, cmd_write, rsp_valid, rsp_refused, lock_active, dsp_overflow;
    logic [2:0]        cmd_addr;
    logic [15:0]       cmd_wdata, rsp_rdata, q;
    logic [15:0]       prod_a = 16'hA5C3;
    logic [15:0]       prod_b = 16'h3C5A;
    logic signed [9:0] adc;
    int                mismatches = 0;
    int                compares = 0;
    int                tx[5] = '{0, 100, -10, 300, -500};
    int                ts[5] = '{64, 64, -128, 127, 127};
    int                to[5] = '{16, 16, 5, -100, 100};
    bit                ta[5] = '{0, 1, 0, 1, 1};

    selk_top i_dut (.clk(clk), .sys_rst(sys_rst), .ce(ce), .prod_load(prod_load),
        .prod_data_a(prod_a), .prod_data_b(prod_b), .adc_value(adc), .cmd_valid(cmd_valid),
        .cmd_write(cmd_write), .cmd_addr(cmd_addr), .cmd_wdata(cmd_wdata),
        .rsp_valid(rsp_valid), .rsp_refused(rsp_refused), .rsp_rdata(rsp_rdata),
        .lock_active(lock_active), .dsp_overflow(dsp_overflow));
    selk_prog i_prog (.clk(clk), .rsp_valid(rsp_valid), .rsp_refused(rsp_refused),
        .rsp_rdata(rsp_rdata), .cmd_valid(cmd_valid), .cmd_write(cmd_write),
        .cmd_addr(cmd_addr), .cmd_wdata(cmd_wdata));

    // Clock at 25 ns
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        compares++;
        if (got !== exp) begin
            mismatches++;
            $display("unexpected %s: expected %h seen %h", what, exp, got);
        end
    endtask
    // Command plus check of its answer
    task automatic cmd(input logic wr, input logic [2:0] a, input logic [15:0] d,
                       input logic [15:0] eq, input logic erf);
        i_prog.xfer(wr, a, d, q, rf, ok);
        chk("answer valid", 16'h0001, {15'h0000, ok});
        chk("refused", {15'h0000, erf}, {15'h0000, rf});
        chk("read data", eq, q);
    endtask
    // Reset held ten cycles stands for a power cycle
    task automatic power_cycle();
        @(negedge clk);
        sys_rst = 1'b1;
        repeat (10) @(negedge clk);
        sys_rst = 1'b0;
    endtask
    // Expected processed value, saturated to ten signed bits
    function automatic logic [15:0] expect_y(input int x, input int s, input int o, input bit al);
        int y;
        y = ((x - (al ? o * 4 : o)) * s) >>> 6;
        if (y > 511) y = 511;
        if (y < -512) y = -512;
        return 16'(y);
    endfunction
    task automatic wrap_up();
        $display("compares %0d mismatches %0d", compares, mismatches);
        if (mismatches == 0 && compares > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    // Watchdog against a hang
    initial begin
        repeat (3000) @(posedge clk);
        mismatches++;
        wrap_up();
    end
    // Main sequence
    initial begin
        sys_rst = 1'b1;
        ce = 1'b1;
        prod_load = 1'b1;
        adc = 10'sh000;
        @(negedge clk);
        prod_load = 1'b0;
        repeat (9) @(negedge clk);
        sys_rst = 1'b0;
        power_cycle();
        cmd(1'b0, selk_pkg::ADDR_PROD_A, 16'h0000, prod_a, 1'b0);
        cmd(1'b1, selk_pkg::ADDR_PROD_B, 16'h1111, 16'h0000, 1'b1);
        cmd(1'b0, selk_pkg::ADDR_PROD_B, 16'h0000, prod_b, 1'b0);
        cmd(1'b0, 3'h7, 16'h0000, 16'h0000, 1'b1);
        $display("test production done");
        for (int i = 0; i < 5; i++) begin
            adc = 10'(tx[i]);
            cmd(1'b1, selk_pkg::ADDR_CUST_I, {8'(ts[i]), 8'(to[i])}, 16'h0000, 1'b0);
            cmd(1'b1, selk_pkg::ADDR_CUST_II, {2'b00, ta[i], 13'h0000}, 16'h0000, 1'b0);
            repeat (3) @(negedge clk);
            cmd(1'b0, selk_pkg::ADDR_DIG_OUT, 16'h0000, expect_y(tx[i], ts[i], to[i], ta[i]), 1'b0);
            chk("overflow", {15'h0000, i > 2}, {15'h0000, dsp_overflow});
        end
        $display("test datapath done");
        cmd(1'b1, selk_pkg::ADDR_CUST_II, 16'h4000, 16'h0000, 1'b0);
        cmd(1'b0, selk_pkg::ADDR_CUST_II, 16'h0000, 16'h4000, 1'b0);
        chk("lock active", 16'h0000, {15'h0000, lock_active});
        cmd(1'b1, selk_pkg::ADDR_CUST_I, 16'h1234, 16'h0000, 1'b0);
        power_cycle();
        chk("lock active", 16'h0001, {15'h0000, lock_active});
        cmd(1'b1, selk_pkg::ADDR_CUST_I, 16'hABCD, 16'h0000, 1'b1);
        cmd(1'b0, selk_pkg::ADDR_CUST_I, 16'h0000, 16'h1234, 1'b0);
        cmd(1'b1, selk_pkg::ADDR_CUST_II, 16'h0000, 16'h0000, 1'b1);
        power_cycle();
        cmd(1'b0, selk_pkg::ADDR_CUST_II, 16'h0000, 16'h4000, 1'b0);
        chk("lock active", 16'h0001, {15'h0000, lock_active});
        cmd(1'b0, selk_pkg::ADDR_PROD_A, 16'h0000, prod_a, 1'b0);
        $display("test lock done");
        wrap_up();
    end
endmodule
